/* sdc_pkg.sv */
// Constants, command codes, request opcodes and timing counts for the SDRAM command host.
// Assumes a single 40 MHz clock that also clocks the memory, and a two-bank part.
// Function
// R1 - Memory samples every pin on rising clock
// R2 - Command code from chip select, RAS, CAS, WE
// R3 - Refresh then no-op, idle after close delay
// R4 - No other command while refresh runs; the host still lets a close or close-all through while rp_cnt counts
// R5 - After mode load, no-op returns idle; close harmless
// R6 - After mode load wait; column commands illegal
// R7 - Mode load drives opcode onto A0..A11
// R8 - Mode load and refresh need both banks idle
// R9 - Row open only to an idle bank
// R10 - Read and store only to active bank
// R11 - A11 selects bank; A8, A9 ignored
// R12 - Refresh address pins are don't care
// R13 - Burst stop only with full page burst
// R14 - Second row open waits open-to-open delay
// R15 - Close waits minimum open-to-close time
// R16 - Column waits open-to-column; auto-precharge closes bank
// R17 - Clock enable fall, both idle, enters power-down
// R18 - Clock enable fall with refresh enters self-refresh
// R19 - Self-refresh exit: enable rise with no-op
// R20 - Recovery: idle after row cycle, or power-down
// R21 - Power-down ends on enable rise with no-op
// R22 - Clock enable low suspends an active bank
// R23 - Illegal command flagged, bank state unchanged
package sdc_pkg;

    localparam int CLK_NS = 25;                      // Clock period
    localparam int CW     = 10;                      // Timer width, holds a full page burst

    // Least time in ns to whole cycles, never below one
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    // Timing figures (plain defaults)
    localparam int CTI_NS   = 20;                    // close_to_idle_delay
    localparam int TRCD_NS  = 20;                    // Open-to-column delay
    localparam int TRAS_NS  = 45;                    // Open-to-close minimum
    localparam int OTOD_NS  = 15;                    // open_to_open_delay
    localparam int TRC_NS   = 67;                    // Row cycle time
    localparam int CTI_CYC  = cyc_up(CTI_NS);
    localparam int TRCD_CYC = cyc_up(TRCD_NS);
    localparam int TRAS_CYC = cyc_up(TRAS_NS);
    localparam int OTOD_CYC = cyc_up(OTOD_NS);
    localparam int TRC_CYC  = cyc_up(TRC_NS);
    localparam int TMLD_CYC = 2;                     // mode_load_delay and mode_to_command_delay

    // Memory command codes {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_DESEL     = 4'hF;     // chip_unselected_cmd
    localparam logic [3:0] CMD_NOP       = 4'h7;
    localparam logic [3:0] CMD_BSTOP     = 4'h6;     // burst_stop_cmd
    localparam logic [3:0] CMD_READ      = 4'h5;
    localparam logic [3:0] CMD_STORE     = 4'h4;     // store_column_cmd
    localparam logic [3:0] CMD_ROW_OPEN  = 4'h3;     // row_open_cmd
    localparam logic [3:0] CMD_CLOSE     = 4'h2;
    localparam logic [3:0] CMD_REFRESH   = 4'h1;
    localparam logic [3:0] CMD_MODE_LOAD = 4'h0;     // mode_load_cmd

    // User request opcodes
    localparam logic [3:0] OP_ROW_OPEN  = 4'h0;
    localparam logic [3:0] OP_READ      = 4'h1;
    localparam logic [3:0] OP_STORE     = 4'h2;
    localparam logic [3:0] OP_CLOSE     = 4'h3;
    localparam logic [3:0] OP_CLOSE_ALL = 4'h4;      // close_all_banks_cmd
    localparam logic [3:0] OP_REFRESH   = 4'h5;
    localparam logic [3:0] OP_MODE_LOAD = 4'h6;
    localparam logic [3:0] OP_BSTOP     = 4'h7;
    localparam logic [3:0] OP_PD_ENTER  = 4'h8;
    localparam logic [3:0] OP_PD_EXIT   = 4'h9;
    localparam logic [3:0] OP_SR_ENTER  = 4'hA;
    localparam logic [3:0] OP_SR_EXIT   = 4'hB;
    localparam logic [3:0] OP_SUSPEND   = 4'hC;
    localparam logic [3:0] OP_RESUME    = 4'hD;

    // Address layout
    localparam int ADDR_W     = 12;
    localparam int BIT_AUTOPR = 10;                  // Auto-precharge / all-banks flag
    localparam int BIT_BANK   = 11;                  // Bank select
    localparam logic [2:0] BL_FULL = 3'h7;           // Full page burst code

    // Reset values
    localparam logic [3:0]        RST_CMD  = CMD_NOP;
    localparam logic              RST_CKE  = 1'b1;
    localparam logic [ADDR_W-1:0] RST_MODE = 12'h000;

    // Power state of the memory as the host sees it
    typedef enum logic [2:0] {PW_RUN, PW_PDOWN, PW_SELF, PW_RECOV, PW_SUSP} sdc_pwr_t;

endpackage : sdc_pkg

/* sdc_host.sv */
// Host-side command sequencer for a two-bank SDRAM: takes user requests and drives
// chip select, RAS, CAS, WE, address and clock enable under the memory's timing.
// Assumes the memory samples these outputs on the same rising clock edge.
`timescale 1ns/1ps
module sdc_host
    import sdc_pkg::*;
#(
    parameter int P_CTI_CYC  = CTI_CYC,
    parameter int P_TRCD_CYC = TRCD_CYC,
    parameter int P_TRAS_CYC = TRAS_CYC,
    parameter int P_OTOD_CYC = OTOD_CYC,
    parameter int P_TRC_CYC  = TRC_CYC,
    parameter int P_TMLD_CYC = TMLD_CYC
)(
    input  wire logic              i_clk,
    input  wire logic              i_rst,
    input  wire logic              i_req_valid,   // Request present
    input  wire logic [3:0]        i_req_op,      // Request opcode
    input  wire logic              i_req_bank,    // Target bank
    input  wire logic              i_req_autopre, // Auto-precharge on read/store
    input  wire logic [ADDR_W-1:0] i_req_addr,    // Row, column or opcode
    output logic                   o_req_ready,   // Request may be taken
    output logic                   o_req_err,     // Taken request was illegal
    output logic                   o_cs_n,
    output logic                   o_ras_n,
    output logic                   o_cas_n,
    output logic                   o_we_n,
    output logic [ADDR_W-1:0]      o_addr,
    output logic                   o_cke,
    output logic [1:0]             o_bank_open,   // Banks active
    output logic [2:0]             o_pwr          // Power state code
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    logic [3:0]        cmd;                       // Registered command code
    logic [3:0]        next_cmd;
    logic [ADDR_W-1:0] addr, next_addr;           // Registered address pins
    logic              cke, next_cke;             // Registered clock enable
    sdc_pwr_t          pwr, next_pwr;             // Power state
    logic [ADDR_W-1:0] mode_reg, next_mode_reg;   // Copy of the memory's opcode
    logic [1:0]        open, next_open;           // Bank active flags
    logic [CW-1:0]     rcd_cnt [2];               // Open-to-column timers
    logic [CW-1:0]     ras_cnt [2];               // Open-to-close timers
    logic [CW-1:0]     ap_cnt  [2];               // Auto-precharge completion timers
    logic [CW-1:0]     next_rcd [2];
    logic [CW-1:0]     next_ras [2];
    logic [CW-1:0]     next_ap  [2];
    logic [CW-1:0]     rp_cnt, next_rp;           // Close/refresh to idle
    logic [CW-1:0]     mrd_cnt, next_mrd;         // Mode load delay
    logic [CW-1:0]     rrd_cnt, next_rrd;         // Open-to-open delay
    logic [CW-1:0]     rc_cnt, next_rc;           // Self-refresh recovery
    logic              legal;                     // Opcode allowed now
    logic              stall;                     // Timing not yet met
    logic              accept;                    // Request taken this cycle
    int                bk;                        // Target bank index

    // Timer step toward zero
    function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
        return (v != '0) ? v - 1'b1 : '0;
    endfunction : dec

    // Burst length in cycles from the mode register code
    function automatic logic [CW-1:0] burst_cycles(input logic [2:0] code);
        case (code)
            3'h0:    return CW'(1);
            3'h1:    return CW'(2);
            3'h2:    return CW'(4);
            3'h3:    return CW'(8);
            default: return CW'(256);
        endcase
    endfunction : burst_cycles

    ////////////////////////////////////////////////////////////////////////////
    // Legality and stall decode for the request at hand
    always_comb begin
        bk    = int'(i_req_bank);
        legal = 1'b0;
        stall = 1'b0;
        case (pwr)
            PW_RUN: begin
                case (i_req_op)
                    OP_ROW_OPEN: begin
                        legal = !open[bk];                                        // [R9]
                        stall = (ap_cnt[bk] != '0) || (rp_cnt != '0) ||
                                (mrd_cnt != '0) || (rrd_cnt != '0);               // [R6] [R14]
                    end
                    OP_READ, OP_STORE: begin
                        legal = open[bk];                                         // [R10]
                        stall = (rcd_cnt[bk] != '0);                              // [R16]
                    end
                    OP_CLOSE: begin
                        legal = 1'b1;                                             // [R5]
                        stall = open[bk] && (ras_cnt[bk] != '0);                  // [R15]
                    end
                    OP_CLOSE_ALL: begin
                        legal = 1'b1;
                        stall = (open[0] && ras_cnt[0] != '0) || (open[1] && ras_cnt[1] != '0); // [R15]
                    end
                    OP_REFRESH, OP_MODE_LOAD, OP_PD_ENTER, OP_SR_ENTER: begin
                        legal = (open == 2'b00);                                  // [R8] [R17] [R18]
                        stall = (ap_cnt[0] != '0) || (ap_cnt[1] != '0) ||
                                (rp_cnt != '0) || (mrd_cnt != '0);                // [R3] [R4] [R6]
                    end
                    OP_BSTOP: begin
                        legal = (open != 2'b00) && (mode_reg[2:0] == BL_FULL);    // [R13]
                    end
                    OP_SUSPEND: begin
                        legal = (open != 2'b00);                                  // [R22]
                    end
                    default: legal = 1'b0;                                        // [R23]
                endcase
            end
            // Only power-down is allowed early; other work waits for the row cycle
            PW_RECOV: begin
                legal = (i_req_op == OP_PD_ENTER) || (rc_cnt == '0);              // [R20]
                stall = (i_req_op != OP_PD_ENTER);
            end
            PW_PDOWN: legal = (i_req_op == OP_PD_EXIT);                           // [R21]
            PW_SELF:  legal = (i_req_op == OP_SR_EXIT);                           // [R19]
            PW_SUSP:  legal = (i_req_op == OP_RESUME);                            // [R22]
            default:  legal = 1'b0;
        endcase
    end

    // Handshake: timing stalls hold ready low; illegal ops are taken and flagged
    assign o_req_ready = !stall;
    assign accept      = i_req_valid && !stall;
    assign o_req_err   = accept && !legal;                                        // [R23]

    ////////////////////////////////////////////////////////////////////////////
    // Next values of pins, power state, banks and timers
    always_comb begin
        next_cmd      = CMD_NOP;
        next_addr     = '0;                                                       // [R12]
        next_cke      = cke;
        next_pwr      = pwr;
        next_mode_reg = mode_reg;
        next_open     = open;
        next_rp       = dec(rp_cnt);
        next_mrd      = dec(mrd_cnt);
        next_rrd      = dec(rrd_cnt);
        next_rc       = dec(rc_cnt);
        for (int b = 0; b < 2; b++) begin
            next_rcd[b] = dec(rcd_cnt[b]);
            next_ras[b] = dec(ras_cnt[b]);
            next_ap[b]  = dec(ap_cnt[b]);
        end
        // Recovery ends by itself after the row cycle
        if (pwr == PW_RECOV && rc_cnt == '0 && !(accept && legal)) begin
            next_pwr = PW_RUN;                                                    // [R20]
        end
        if (accept && legal) begin
            case (i_req_op)
                OP_ROW_OPEN: begin
                    next_cmd           = CMD_ROW_OPEN;                            // [R2]
                    next_addr          = {i_req_bank, i_req_addr[BIT_AUTOPR:0]};  // [R11]
                    next_open[bk]      = 1'b1;
                    next_rcd[bk]       = CW'(P_TRCD_CYC - 1);                     // [R16]
                    next_ras[bk]       = CW'(P_TRAS_CYC - 1);                     // [R15]
                    next_rrd           = CW'(P_OTOD_CYC - 1);                     // [R14]
                end
                OP_READ, OP_STORE: begin
                    next_cmd  = (i_req_op == OP_READ) ? CMD_READ : CMD_STORE;
                    // Column on A7..A0; A9, A8 driven low as don't care
                    next_addr = {i_req_bank, i_req_autopre, 2'b00, i_req_addr[7:0]}; // [R11]
                    if (i_req_autopre) begin
                        next_open[bk] = 1'b0;                                     // [R16]
                        next_ap[bk]   = burst_cycles(mode_reg[2:0]) + CW'(P_CTI_CYC - 1);
                    end
                end
                OP_CLOSE, OP_CLOSE_ALL: begin
                    next_cmd                = CMD_CLOSE;
                    next_addr[BIT_BANK]     = i_req_bank;
                    next_addr[BIT_AUTOPR]   = (i_req_op == OP_CLOSE_ALL);
                    if (i_req_op == OP_CLOSE_ALL) begin
                        next_open = 2'b00;
                    end else begin
                        next_open[bk] = 1'b0;
                    end
                    if (open != 2'b00) begin
                        next_rp = CW'(P_CTI_CYC - 1);                             // [R3]
                    end
                end
                OP_REFRESH: begin
                    next_cmd = CMD_REFRESH;
                    next_rp  = CW'(P_CTI_CYC - 1);                                // [R3] [R4]
                end
                OP_MODE_LOAD: begin
                    next_cmd      = CMD_MODE_LOAD;
                    next_addr     = i_req_addr;                                   // [R7]
                    next_mode_reg = i_req_addr;
                    next_mrd      = CW'(P_TMLD_CYC - 1);                          // [R5] [R6]
                end
                OP_BSTOP: next_cmd = CMD_BSTOP;                                   // [R13]
                OP_PD_ENTER: begin
                    next_cke = 1'b0;                                              // [R17] [R20]
                    next_pwr = PW_PDOWN;
                end
                OP_SR_ENTER: begin
                    next_cmd = CMD_REFRESH;                                       // [R18]
                    next_cke = 1'b0;
                    next_pwr = PW_SELF;
                end
                OP_SR_EXIT: begin
                    next_cke = 1'b1;                                              // [R19]
                    next_pwr = PW_RECOV;
                    next_rc  = CW'(P_TRC_CYC - 1);                                // [R20]
                end
                OP_PD_EXIT: begin
                    next_cke = 1'b1;                                              // [R21]
                    next_pwr = PW_RUN;
                end
                OP_SUSPEND: begin
                    next_cke = 1'b0;                                              // [R22]
                    next_pwr = PW_SUSP;
                end
                OP_RESUME: begin
                    next_cke = 1'b1;                                              // [R22]
                    next_pwr = PW_RUN;
                end
                default: next_cmd = CMD_NOP;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; pins leave from flops so the memory sees clean edges
    always_ff @(posedge i_clk) begin                                              // [R1]
        if (i_rst) begin
            cmd      <= RST_CMD;
            addr     <= '0;
            cke      <= RST_CKE;
            pwr      <= PW_RUN;
            mode_reg <= RST_MODE;
            open     <= 2'b00;
            rp_cnt   <= '0;
            mrd_cnt  <= '0;
            rrd_cnt  <= '0;
            rc_cnt   <= '0;
            for (int b = 0; b < 2; b++) begin
                rcd_cnt[b] <= '0;
                ras_cnt[b] <= '0;
                ap_cnt[b]  <= '0;
            end
        end else begin
            cmd      <= next_cmd;
            addr     <= next_addr;
            cke      <= next_cke;
            pwr      <= next_pwr;
            mode_reg <= next_mode_reg;
            open     <= next_open;
            rp_cnt   <= next_rp;
            mrd_cnt  <= next_mrd;
            rrd_cnt  <= next_rrd;
            rc_cnt   <= next_rc;
            for (int b = 0; b < 2; b++) begin
                rcd_cnt[b] <= next_rcd[b];
                ras_cnt[b] <= next_ras[b];
                ap_cnt[b]  <= next_ap[b];
            end
        end
    end

    // Pin mapping
    assign {o_cs_n, o_ras_n, o_cas_n, o_we_n} = cmd;                              // [R2]
    assign o_addr      = addr;
    assign o_cke       = cke;
    assign o_bank_open = open;
    assign o_pwr       = pwr;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on what the host drives
    logic     idle_cmd;                           // No-op or deselect on the pins
    logic [7:0] since_open;                       // Cycles since last row open, saturating
    assign idle_cmd = (cmd == CMD_NOP) || cmd[3];

    // Helper counter for open-to-open spacing
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            since_open <= 8'hFF;
        end else if (cmd == CMD_ROW_OPEN) begin
            since_open <= 8'h01;
        end else if (since_open != 8'hFF) begin
            since_open <= since_open + 8'h01;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_mode_load;
        cmd == CMD_MODE_LOAD;
    endsequence
    sequence s_sr_exit;
        ($past(pwr) == PW_SELF) && $rose(o_cke);
    endsequence

    property p_both_idle;
        (cmd == CMD_MODE_LOAD || cmd == CMD_REFRESH) |-> ($past(open) == 2'b00);
    endproperty
    a_both_idle: assert property (p_both_idle) else $error("mode load or refresh with a bank open"); // [R8]

    property p_open_idle;
        (cmd == CMD_ROW_OPEN) |-> !(o_addr[BIT_BANK] ? $past(open[1]) : $past(open[0])) && open[o_addr[BIT_BANK]];
    endproperty
    a_open_idle: assert property (p_open_idle) else $error("row open to an active bank"); // [R9]

    property p_col_active;
        (cmd == CMD_READ || cmd == CMD_STORE) |->
            (o_addr[BIT_BANK] ? $past(open[1]) : $past(open[0])) &&
            ((o_addr[BIT_BANK] ? $past(rcd_cnt[1]) : $past(rcd_cnt[0])) == '0);
    endproperty
    a_col_active: assert property (p_col_active) else $error("column command too early or to idle bank"); // [R10]

    property p_open_spacing;
        (cmd == CMD_ROW_OPEN) |-> int'(since_open) >= P_OTOD_CYC;
    endproperty
    a_open_spacing: assert property (p_open_spacing) else $error("row opens too close together"); // [R14]

    property p_close_time;
        (cmd == CMD_CLOSE) && !o_addr[BIT_AUTOPR] && (o_addr[BIT_BANK] ? $past(open[1]) : $past(open[0])) |->
            ((o_addr[BIT_BANK] ? $past(ras_cnt[1]) : $past(ras_cnt[0])) == '0);
    endproperty
    a_close_time: assert property (p_close_time) else $error("bank closed before open-to-close time"); // [R15]

    property p_bstop_full;
        (cmd == CMD_BSTOP) |-> (mode_reg[2:0] == BL_FULL) && (open != 2'b00);
    endproperty
    a_bstop_full: assert property (p_bstop_full) else $error("burst stop without full page burst"); // [R13]

    property p_mode_wait;
        s_mode_load |=> idle_cmd || (cmd == CMD_CLOSE);
    endproperty
    a_mode_wait: assert property (p_mode_wait) else $error("command issued inside mode load delay"); // [R6]

    property p_refresh_wait;
        (cmd == CMD_ROW_OPEN || cmd == CMD_REFRESH || cmd == CMD_MODE_LOAD) |-> ($past(rp_cnt) == '0);
    endproperty
    a_refresh_wait: assert property (p_refresh_wait) else $error("command issued while refresh runs"); // [R4]

    property p_pd_entry;
        $fell(o_cke) && idle_cmd && (open == 2'b00) |-> (pwr == PW_PDOWN);
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("power-down entry not tracked"); // [R17]

    property p_sr_exit;
        s_sr_exit |-> idle_cmd && (pwr == PW_RECOV);
    endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("self-refresh exit without no-op"); // [R19]

    property p_pd_hold;
        (pwr == PW_PDOWN || pwr == PW_SELF) |-> !o_cke && (open == 2'b00);
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("clock enable high in power-down"); // [R21]

    property p_suspend;
        (pwr == PW_SUSP) |-> !o_cke && (open != 2'b00) && idle_cmd;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend without active bank"); // [R22]

endmodule : sdc_host

/* sdc_mem_model.sv */
// Behavioural two-bank memory standing on the far side of the command host.
// Assumes it shares the host's clock; the memory has no reset pin.
`timescale 1ns/1ps
module sdc_mem_model
    import sdc_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_cs_n,
    input  wire logic              i_ras_n,
    input  wire logic              i_cas_n,
    input  wire logic              i_we_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_cke,
    output logic                   o_err = 1'b0,     // Sticky protocol error
    output logic [ADDR_W-1:0]      o_mode = 12'h000, // Mode register
    output logic [1:0]             o_open = 2'h0     // Banks active
);
    logic       cke_q  = 1'b1;                      // Clock enable at last edge
    logic       self_q = 1'b0;                      // In self-refresh
    logic [3:0] cmd;                                // Decoded command code
    logic       bk;                                 // Bank picked by A11
    assign cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
    assign bk  = i_addr[BIT_BANK];
    ////////////////////////////////////////////////////////////////
    // Rising-edge sampling only; illegal commands leave banks alone
    always @(posedge i_clk) begin
        cke_q <= i_cke;
        if (!cke_q) begin // Pins ignored while enable low
            if (self_q && i_cke) begin
                self_q <= 1'b0;
                if (!(cmd[3] || cmd[2:1] == 2'h3)) o_err <= 1'b1;
            end
        end else if (!cmd[3]) begin
            case (cmd)
                CMD_ROW_OPEN: if (o_open[bk]) o_err <= 1'b1; else o_open[bk] <= 1'b1;
                CMD_READ, CMD_STORE: if (!o_open[bk]) o_err <= 1'b1;
                CMD_CLOSE: if (i_addr[BIT_AUTOPR]) o_open <= 2'h0; else o_open[bk] <= 1'b0;
                CMD_REFRESH, CMD_MODE_LOAD: begin // Address ignored on refresh
                    if (o_open != 2'h0) o_err <= 1'b1;
                    else if (cmd == CMD_MODE_LOAD) o_mode <= i_addr;
                    else if (!i_cke) self_q <= 1'b1;
                end
                default: ; // No-op and burst stop change nothing
            endcase
        end
    end
endmodule : sdc_mem_model

/* sdc_tb.sv */
// Self-checking bench: requests into the command host, pins and memory model checked.
// Assumes the package's default timing counts and a 40 MHz clock.
`timescale 1ns/1ps
module testbench;
    import sdc_pkg::*;
    logic              i_clk = 1'b0, i_rst = 1'b1, i_req_valid = 1'b0, i_req_bank = 1'b0, i_req_autopre = 1'b0;
    logic [3:0]        i_req_op = 4'h0;                                  // Request opcode
    logic [ADDR_W-1:0] i_req_addr = 12'h000, o_addr, m_mode;             // Addresses
    logic              o_req_ready, o_req_err, o_cs_n, o_ras_n, o_cas_n, o_we_n, o_cke, m_err, err_seen;
    logic [1:0]        o_bank_open, m_open;                              // Bank flags
    logic [2:0]        o_pwr;                                            // Power state
    int                fail_count = 0, num_checks = 0;
    sdc_host dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_req_valid(i_req_valid), .i_req_op(i_req_op),
        .i_req_bank(i_req_bank), .i_req_autopre(i_req_autopre), .i_req_addr(i_req_addr),
        .o_req_ready(o_req_ready), .o_req_err(o_req_err), .o_cs_n(o_cs_n), .o_ras_n(o_ras_n),
        .o_cas_n(o_cas_n), .o_we_n(o_we_n), .o_addr(o_addr), .o_cke(o_cke), .o_bank_open(o_bank_open),
        .o_pwr(o_pwr));
    sdc_mem_model mem_u (.i_clk(i_clk), .i_cs_n(o_cs_n), .i_ras_n(o_ras_n), .i_cas_n(o_cas_n),
        .i_we_n(o_we_n), .i_addr(o_addr), .i_cke(o_cke), .o_err(m_err), .o_mode(m_mode), .o_open(m_open));
    initial forever #12.5 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One request, held until taken; deselect is read as a no-op
    task automatic do_req(input logic [3:0] op, input logic b, input logic [11:0] a, input logic [3:0] ec);
        int n;
        i_req_op = op; i_req_bank = b; i_req_addr = a; i_req_valid = 1'b1;
        #1;
        for (n = 0; n < 60 && o_req_ready !== 1'b1; n++) begin @(posedge i_clk); #2; end
        if (n == 60) begin chk("ready", 1'b0, 1'b1); tally_and_finish(); end
        else begin
            err_seen = o_req_err;
            @(posedge i_clk); #2;
            chk("cmd", ({o_cs_n, o_ras_n, o_cas_n, o_we_n} === CMD_DESEL) ? CMD_NOP
                : {o_cs_n, o_ras_n, o_cas_n, o_we_n}, ec);
        end
    endtask : do_req
    task automatic s_reset();
        chk("cmd", {o_cs_n, o_ras_n, o_cas_n, o_we_n}, RST_CMD); chk("cke", o_cke, 1'b1);
        chk("open", o_bank_open, 2'h0); chk("pwr", o_pwr, PW_RUN);
    endtask : s_reset
    task automatic s_banks(); // Row open, column, suspend, close all
        do_req(OP_ROW_OPEN, 1'b1, 12'h123, CMD_ROW_OPEN); chk("addr", o_addr, 12'h923);
        chk("open", o_bank_open, 2'h2);
        do_req(OP_READ, 1'b1, 12'h3FF, CMD_READ); chk("addr", o_addr, 12'h8FF);
        do_req(OP_SUSPEND, 1'b1, 12'h000, CMD_NOP); chk("pwr", o_pwr, PW_SUSP);
        chk("cke", o_cke, 1'b0);
        do_req(OP_RESUME, 1'b1, 12'h000, CMD_NOP); chk("cke", o_cke, 1'b1);
        do_req(OP_CLOSE_ALL, 1'b0, 12'h000, CMD_CLOSE); chk("a10", o_addr[BIT_AUTOPR], 1'b1);
        do_req(OP_READ, 1'b0, 12'h001, CMD_NOP); chk("err", err_seen, 1'b1);
    endtask : s_banks
    task automatic s_mode(); // Mode load, spacing, refresh
        do_req(OP_MODE_LOAD, 1'b0, 12'h027, CMD_MODE_LOAD); chk("addr", o_addr, 12'h027);
        i_req_op = OP_REFRESH; i_req_valid = 1'b1; #1 chk("ready", o_req_ready, 1'b0);
        do_req(OP_REFRESH, 1'b0, 12'h000, CMD_REFRESH); chk("mode", m_mode, 12'h027);
    endtask : s_mode
    task automatic s_power(); // Power-down, self-refresh and recovery
        int n;
        do_req(OP_PD_ENTER, 1'b0, 12'h000, CMD_NOP); chk("pwr", o_pwr, PW_PDOWN);
        chk("cke", o_cke, 1'b0);
        do_req(OP_PD_EXIT, 1'b0, 12'h000, CMD_NOP); chk("pwr", o_pwr, PW_RUN);
        do_req(OP_SR_ENTER, 1'b0, 12'h000, CMD_REFRESH); chk("cke", o_cke, 1'b0);
        do_req(OP_SR_EXIT, 1'b0, 12'h000, CMD_NOP); chk("pwr", o_pwr, PW_RECOV);
        i_req_valid = 1'b0;
        for (n = 0; n <= TRC_CYC + 1 && o_pwr !== PW_RUN; n++) begin @(posedge i_clk); #2; end
        chk("pwr", o_pwr, PW_RUN); chk("trc", n, TRC_CYC);
    endtask : s_power
    initial begin
        repeat (4) @(posedge i_clk);
        #2 i_rst = 1'b0;
        s_reset();
        s_banks();
        s_mode();
        s_power();
        chk("model", {m_err, m_open}, 3'h0);
        tally_and_finish();
    end
endmodule : testbench
